/* File: logic/cih_pkg.sv */
// Purpose: shared constants and types of the cpu interrupt handling block
// Assumes: one clock, asynchronous active-low reset
// Notes:   Functional notes follow
//
// Functional notes
// - each source and reset own vector
// - take only if source and global enabled
// - boot lock may suppress by pc region
// - vectors default at lowest program addresses
// - lower vector wins, reset then request zero
// - relocate bit moves table to boot start
// - boot reset fuse moves reset vector
// - accepting interrupt clears global enable
// - software may re-enable, allowing nesting
// - return instruction sets global enable
// - hardware clears flag when vectoring
// - writing one clears a flag
// - disabled source flag held until serviced
// - pending flags serviced in priority order
// - level sources request only while present
// - one main instruction after return
// - status register not saved or restored
// - disable instruction blocks same-cycle interrupt
// - runs on undivided cpu clock
// - two-operand alu op in one cycle
// - 16-bit stack pointer, two bytes, reset zero
// - entry takes four cycles, pushing pc
// - return takes four cycles, sp plus two
// - instruction after enable runs first
// - multi-cycle instruction completes first
package cih_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [3:0] CIH_ADDR_SP_LOW   = 4'h0;
  localparam logic [3:0] CIH_ADDR_SP_HIGH  = 4'h1;
  localparam logic [3:0] CIH_ADDR_FLAGS    = 4'h2;
  localparam logic [3:0] CIH_ADDR_ENABLES  = 4'h3;
  localparam logic [3:0] CIH_ADDR_CONTROL  = 4'h4;
  localparam logic [3:0] CIH_ADDR_STATUS   = 4'h5;
  localparam logic [3:0] CIH_ADDR_BOOT_LO  = 4'h6;
  localparam logic [3:0] CIH_ADDR_BOOT_HI  = 4'h7;

  // control bit positions
  localparam int CIH_CTRL_RELOCATE_BIT = 0;
  localparam int CIH_CTRL_GIE_BIT      = 1;

  // reset values
  localparam logic [15:0] CIH_SP_RESET   = 16'h0000;
  localparam logic [15:0] CIH_BOOT_RESET = 16'h3800;

  // timing counts in cpu clock cycles, then the vector stride in bytes
  localparam logic [3:0] CIH_ENTRY_CYCLES = 4'h4;
  localparam logic [3:0] CIH_WAKE_CYCLES  = 4'h4;
  localparam logic [3:0] CIH_RETURN_FROM_INTERRUPT_INSTR_CYCLES  = 4'h4;
  localparam logic [15:0] CIH_VEC_STRIDE  = 16'h0002;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    CIH_RUN   = 4'b0001,
    CIH_WAKE  = 4'b0010,
    CIH_ENTRY = 4'b0100,
    CIH_RET   = 4'b1000
  } cih_state_t;

  // cpu sequencer handshake bundle
  typedef struct packed {
    logic boundary;     // an instruction completes this cycle
    logic sleeping;
    logic sei;
    logic cli;
    logic return_from_interrupt_instr;
  } cih_seq_t;

  // register port bundle
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } cih_reg_req_t;

endpackage : cih_pkg

/* File: logic/cih_core.sv */
// Purpose: interrupt arbitration, vectoring and stack pointer of the cpu
// Assumes: cpu clock undivided, sequencer pulses one cycle each
// Notes:   source 0 is external request zero; reset is vector 0
`timescale 1ns/1ps
module cih_core
  import cih_pkg::*;
#(
  parameter int N_SRC = 8
) (
  input  wire logic                clk,
  input  wire logic                reset_n,
  input  wire cih_reg_req_t        reg_req,
  output logic [7:0]               reg_rdata,
  input  wire cih_seq_t            seq,
  input  wire logic [N_SRC-1:0]    src_event,
  input  wire logic [N_SRC-1:0]    src_level,
  input  wire logic [N_SRC-1:0]    src_is_level,
  input  wire logic [15:0]         pc,
  input  wire logic                boot_reset_vector_fuse,
  input  wire logic                app_section_lock_bit,
  input  wire logic                boot_section_lock_bit,
  output logic                     vector_take,
  output logic [15:0]              vector_addr,
  output logic                     reset_vector_valid,
  output logic                     cpu_stall,
  output logic                     push_pc,
  output logic                     pop_pc,
  output logic [15:0]              stack_pointer
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [N_SRC-1:0] flag_q;
  logic [N_SRC-1:0] enable_q;
  logic             gie_q;
  logic             relocate_q;
  logic [15:0]      boot_start_q;
  logic [7:0]       sp_low_q;
  logic [7:0]       sp_high_q;
  logic             hold_q;        // one main instruction before servicing
  logic             rst_vec_q;
  cih_state_t       state_q;
  logic [3:0]       cnt_q;
  logic [N_SRC-1:0] grant_q;
  logic [7:0]       rdata_q;

  logic [N_SRC-1:0] req;
  logic [N_SRC-1:0] grant;
  logic             any_req;
  logic             suppress;
  logic             accept;
  logic [15:0]      vec_base;
  logic [15:0]      vec_idx;
  logic             wr_flags;
  logic             wr_ctrl;

  assign wr_flags = reg_req.wr && (reg_req.addr == CIH_ADDR_FLAGS);
  assign wr_ctrl  = reg_req.wr && (reg_req.addr == CIH_ADDR_CONTROL);

  // ----------------------------------------------------------------
  // request gathering and priority
  // ----------------------------------------------------------------
  // boot lock suppression: pc inside a locked section blocks servicing while the vector table sits in the other section
  always_comb begin
    suppress = 1'b0;
    if (app_section_lock_bit && (pc < boot_start_q) && relocate_q)
      suppress = 1'b1;
    if (boot_section_lock_bit && (pc >= boot_start_q) && !relocate_q)
      suppress = 1'b1;
  end

  // per source request: latched flag or live level, gated by own enable
  genvar g;
  generate
    for (g = 0; g < N_SRC; g++) begin : g_req
      assign req[g] = enable_q[g] && (src_is_level[g] ? src_level[g] : flag_q[g]);
    end
  endgenerate

  // lowest index means lowest vector, so it wins
  always_comb begin
    grant = '0;
    for (int i = N_SRC - 1; i >= 0; i--) begin
      if (req[i]) begin
        grant    = '0;
        grant[i] = 1'b1;
      end
    end
  end

  assign any_req = |req;

  // take only at a boundary, with global enable, outside the cli cycle
  assign accept = (state_q == CIH_RUN) && seq.boundary && any_req && gie_q
                  && !seq.cli && !seq.sei && !hold_q && !suppress
                  && !seq.return_from_interrupt_instr;

  // ----------------------------------------------------------------
  // interrupt flags
  // ----------------------------------------------------------------
  // events set, write-one clears, vectoring clears; set wins over clear
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flag_q <= '0;
    end else begin
      for (int i = 0; i < N_SRC; i++) begin
        if (src_event[i])
          flag_q[i] <= 1'b1;
        else if (wr_flags && reg_req.wdata[i])
          flag_q[i] <= 1'b0;
        else if (accept && grant[i] && !src_is_level[i])
          flag_q[i] <= 1'b0;
      end
    end
  end

  // individual enables
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      enable_q <= '0;
    end else if (reg_req.wr && reg_req.addr == CIH_ADDR_ENABLES) begin
      enable_q <= reg_req.wdata[N_SRC-1:0];
    end
  end

  // ----------------------------------------------------------------
  // global enable
  // ----------------------------------------------------------------
  // status is never saved or restored by hardware here
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gie_q <= 1'b0;
    end else if (accept) begin
      gie_q <= 1'b0;
    end else if (seq.cli) begin
      gie_q <= 1'b0;
    end else if (state_q == CIH_RET && cnt_q == CIH_RETURN_FROM_INTERRUPT_INSTR_CYCLES - 4'h1) begin
      gie_q <= 1'b1;
    end else if (seq.sei) begin
      gie_q <= 1'b1;
    end else if (wr_ctrl) begin
      gie_q <= reg_req.wdata[CIH_CTRL_GIE_BIT];
    end
  end

  // one instruction runs after sei or after return before servicing
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hold_q <= 1'b0;
    end else if (seq.sei || (state_q == CIH_RET && cnt_q == CIH_RETURN_FROM_INTERRUPT_INSTR_CYCLES - 4'h1)) begin
      hold_q <= 1'b1;
    end else if (seq.boundary && state_q == CIH_RUN) begin
      hold_q <= 1'b0;
    end
  end

  // vector table placement
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      relocate_q   <= 1'b0;
      boot_start_q <= CIH_BOOT_RESET;
    end else begin
      if (wr_ctrl)
        relocate_q <= reg_req.wdata[CIH_CTRL_RELOCATE_BIT];
      if (reg_req.wr && reg_req.addr == CIH_ADDR_BOOT_LO)
        boot_start_q[7:0] <= reg_req.wdata;
      if (reg_req.wr && reg_req.addr == CIH_ADDR_BOOT_HI)
        boot_start_q[15:8] <= reg_req.wdata;
    end
  end

  // ----------------------------------------------------------------
  // entry and return sequencing
  // ----------------------------------------------------------------
  // runs on the raw cpu clock, so every count here is in cpu cycles
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= CIH_RUN;
      cnt_q   <= 4'h0;
      grant_q <= '0;
    end else begin
      unique case (state_q)
        CIH_RUN: begin
          cnt_q <= 4'h0;
          if (accept) begin
            grant_q <= grant;
            state_q <= seq.sleeping ? CIH_WAKE : CIH_ENTRY;
          end else if (seq.return_from_interrupt_instr && seq.boundary) begin
            state_q <= CIH_RET;
          end
        end
        CIH_WAKE: begin
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == CIH_WAKE_CYCLES - 4'h1) begin
            cnt_q   <= 4'h0;
            state_q <= CIH_ENTRY;
          end
        end
        CIH_ENTRY: begin
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == CIH_ENTRY_CYCLES - 4'h1) begin
            cnt_q   <= 4'h0;
            state_q <= CIH_RUN;
          end
        end
        CIH_RET: begin
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == CIH_RETURN_FROM_INTERRUPT_INSTR_CYCLES - 4'h1) begin
            cnt_q   <= 4'h0;
            state_q <= CIH_RUN;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // stack pointer
  // ----------------------------------------------------------------
  // two bytes pushed across entry, popped across return
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      {sp_high_q, sp_low_q} <= CIH_SP_RESET;
    end else if (state_q == CIH_ENTRY && cnt_q == 4'h0) begin
      {sp_high_q, sp_low_q} <= {sp_high_q, sp_low_q} - CIH_VEC_STRIDE;
    end else if (state_q == CIH_RET && cnt_q == 4'h0) begin
      {sp_high_q, sp_low_q} <= {sp_high_q, sp_low_q} + CIH_VEC_STRIDE;
    end else if (reg_req.wr && reg_req.addr == CIH_ADDR_SP_LOW) begin
      sp_low_q <= reg_req.wdata;
    end else if (reg_req.wr && reg_req.addr == CIH_ADDR_SP_HIGH) begin
      sp_high_q <= reg_req.wdata;
    end
  end

  // ----------------------------------------------------------------
  // vector address
  // ----------------------------------------------------------------
  // vector n+1 for source n; reset holds vector 0
  always_comb begin
    vec_idx = 16'h0000;
    for (int i = 0; i < N_SRC; i++) begin
      if (grant_q[i])
        vec_idx = 16'(i + 1);
    end
  end

  assign vec_base = relocate_q ? boot_start_q : 16'h0000;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      vector_addr        <= 16'h0000;
      vector_take        <= 1'b0;
      reset_vector_valid <= 1'b0;
      rst_vec_q          <= 1'b1;
    end else begin
      vector_take        <= 1'b0;
      reset_vector_valid <= 1'b0;
      if (rst_vec_q) begin
        rst_vec_q          <= 1'b0;
        reset_vector_valid <= 1'b1;
        vector_addr        <= boot_reset_vector_fuse ? boot_start_q : 16'h0000;
      end else if (state_q == CIH_ENTRY && cnt_q == CIH_ENTRY_CYCLES - 4'h1) begin
        vector_take <= 1'b1;
        vector_addr <= vec_base + 16'(vec_idx * CIH_VEC_STRIDE);
      end
    end
  end

  assign cpu_stall = (state_q != CIH_RUN);
  assign push_pc   = (state_q == CIH_ENTRY) && (cnt_q < 4'h2);
  assign pop_pc    = (state_q == CIH_RET) && (cnt_q < 4'h2);
  assign stack_pointer = {sp_high_q, sp_low_q};

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  // unmapped reads return zero; data valid the cycle after the strobe
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= 8'h00;
    end else if (reg_req.rd) begin
      unique case (reg_req.addr)
        CIH_ADDR_SP_LOW:  rdata_q <= sp_low_q;
        CIH_ADDR_SP_HIGH: rdata_q <= sp_high_q;
        CIH_ADDR_FLAGS:   rdata_q <= 8'(flag_q);
        CIH_ADDR_ENABLES: rdata_q <= 8'(enable_q);
        CIH_ADDR_CONTROL: rdata_q <= {6'h00, gie_q, relocate_q};
        CIH_ADDR_STATUS:  rdata_q <= {4'h0, 4'(state_q)};
        CIH_ADDR_BOOT_LO: rdata_q <= boot_start_q[7:0];
        CIH_ADDR_BOOT_HI: rdata_q <= boot_start_q[15:8];
        default:          rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign reg_rdata = rdata_q;

endmodule // cih_core

/* File: verification/cih_chk.sv */
// Purpose: port-level checks of cih_core
// Assumes: one clock, reset_n async active low
// Notes:   bound into the core after the module
`timescale 1ns/1ps
module cih_chk
  import cih_pkg::*;
#(
  parameter int N_SRC = 8
) (
  input wire logic         clk,
  input wire logic         reset_n,
  input wire cih_reg_req_t reg_req,
  input wire logic [7:0]   reg_rdata,
  input wire cih_seq_t     seq,
  input wire logic         boot_reset_vector_fuse,
  input wire logic         vector_take,
  input wire logic [15:0]  vector_addr,
  input wire logic         reset_vector_valid,
  input wire logic         cpu_stall,
  input wire logic         push_pc,
  input wire logic         pop_pc,
  input wire logic [15:0]  stack_pointer
);
  // ------------------------------
  // checks
  // ------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // a return starts on a boundary that carries the return op
  wire ret_go = seq.return_from_interrupt_instr && seq.boundary && !cpu_stall;
  a_entry_four: assert property ($rose(push_pc) |-> cpu_stall[*4] ##1 vector_take)
    else $error("entry length wrong");
  a_entry_sp: assert property (vector_take |->
    stack_pointer == $past(stack_pointer, 5) - 16'h0002)
    else $error("entry stack step wrong");
  // a sleeping core spends four wake cycles before the push starts
  a_wake_delay: assert property ($rose(cpu_stall) && $past(seq.sleeping) && !$past(seq.return_from_interrupt_instr)
    |-> !push_pc[*4] ##1 push_pc)
    else $error("wake delay wrong");
  a_ret_gap: assert property (ret_go |=> cpu_stall[*4] ##1 !push_pc ##1 !push_pc)
    else $error("return length or gap wrong");
  a_ret_sp: assert property (ret_go |-> ##5
    stack_pointer == $past(stack_pointer, 5) + 16'h0002)
    else $error("return stack step wrong");
  a_ret_pop: assert property (ret_go |=> pop_pc[*2] ##1 !pop_pc)
    else $error("return pop length wrong");
  a_disable_now: assert property (seq.cli && seq.boundary |=> !push_pc)
    else $error("entry beside disable op");
  a_enable_defer: assert property (seq.sei && seq.boundary && !cpu_stall |=> !push_pc[*2])
    else $error("entry right after enable op");
  a_take_once: assert property (vector_take |-> $past(cpu_stall) && !cpu_stall ##1 !vector_take)
    else $error("vector pulse misplaced");
  a_reset_vec: assert property (reset_vector_valid |->
    vector_addr == (boot_reset_vector_fuse ? CIH_BOOT_RESET : 16'h0000))
    else $error("reset vector wrong");
  a_sp_read: assert property (reg_req.rd && reg_req.addr == CIH_ADDR_SP_LOW |=>
    reg_rdata == $past(stack_pointer[7:0]))
    else $error("stack low read wrong");
  c_take: cover property (vector_take);
  c_ret: cover property (ret_go);
  c_cli: cover property (seq.cli && seq.boundary);
  c_wake: cover property ($rose(cpu_stall) && $past(seq.sleeping));
endmodule // cih_chk

bind cih_core cih_chk #(.N_SRC(N_SRC)) u_chk (.clk, .reset_n, .reg_req, .reg_rdata, .seq,
  .boot_reset_vector_fuse, .vector_take, .vector_addr, .reset_vector_valid, .cpu_stall,
  .push_pc, .pop_pc, .stack_pointer);

/* File: verification/cih_seq_model.sv */
// Purpose: instruction sequencer seen by the interrupt core
// Assumes: an op from the bench is held for exactly one boundary
// Notes:   sleeps only when the bench says so; slow mode stretches every instruction
`timescale 1ns/1ps
module cih_seq_model
  import cih_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       cpu_stall,
  input  wire logic [1:0] op,
  input  wire logic       slow,
  input  wire logic       sleep,
  output cih_seq_t        seq
);
  // ------------------------------
  // instruction pacing
  // ------------------------------
  logic ph_q;
  // phase toggle gives two-cycle instructions in slow mode
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) ph_q <= 1'b0;
    else ph_q <= ~ph_q;
  end
  // no boundary while the core stalls, ops ride on a boundary only
  always_comb begin
    seq.boundary = reset_n && !cpu_stall && (!slow || ph_q);
    seq.sleeping = sleep;
    seq.sei      = seq.boundary && op == 2'd1;
    seq.cli      = seq.boundary && op == 2'd2;
    seq.return_from_interrupt_instr     = seq.boundary && op == 2'd3;
  end
endmodule // cih_seq_model

/* File: verification/testbench.sv */
// Purpose: directed test of the interrupt core
// Assumes: sequencer model completes an instruction each free cycle, every other free cycle in slow mode
// Notes:   pc moves only for the boot lock case, one entry is taken asleep
`timescale 1ns/1ps
module testbench
  import cih_pkg::*;
;
  // ------------------------------
  // wiring
  // ------------------------------
  logic         clk = 1'b0;
  logic         reset_n = 1'b0;
  cih_reg_req_t req = '0;
  cih_seq_t     seq;
  logic [7:0]   rdata;
  logic [7:0]   ev = '0, lvl = '0, is_lvl = '0;
  logic         fuse = 1'b1, lock = 1'b0, slow = 1'b0, block = 1'b0, slp = 1'b0;
  logic [1:0]   op = '0;
  logic         take, rvv, stall;
  logic [15:0]  vaddr, pc_v = 16'h0000;
  int           bad_count = 0, n_compared = 0;
  always #10 clk = ~clk;
  cih_core #(.N_SRC(8)) dut (.clk, .reset_n, .reg_req(req), .reg_rdata(rdata), .seq,
    .src_event(ev), .src_level(lvl), .src_is_level(is_lvl), .pc(pc_v),
    .boot_reset_vector_fuse(fuse), .app_section_lock_bit(lock), .boot_section_lock_bit(block),
    .vector_take(take), .vector_addr(vaddr), .reset_vector_valid(rvv), .cpu_stall(stall),
    .push_pc(), .pop_pc(), .stack_pointer());
  cih_seq_model u_seq (.clk, .reset_n, .cpu_stall(stall), .op, .slow, .sleep(slp), .seq);
  // compare and verdict
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic tmo(bit ok);
    if (!ok) begin
      bad_count++;
      give_verdict();
    end
  endtask
  // register cycles; read data stands only in the cycle after the strobe
  task automatic w(logic [3:0] a, logic [7:0] d);
    @(posedge clk) req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk) req.wr <= 1'b0;
  endtask
  task automatic r(logic [3:0] a, logic [7:0] e, string nm);
    @(posedge clk) req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk) req.rd <= 1'b0;
    #1;
    chk(nm, {8'h00, rdata}, {8'h00, e});
  endtask
  task automatic pulse(logic [7:0] m);
    @(posedge clk) ev <= m;
    @(posedge clk) ev <= 8'h00;
  endtask
  // op stands until a boundary takes it; boundary is looked at mid-cycle
  task automatic go(logic [1:0] o);
    int i;
    @(posedge clk) op <= o;
    for (i = 0; i < 20; i++) begin
      @(negedge clk);
      if (seq.boundary === 1'b1) break;
    end
    tmo(i < 20);
    @(posedge clk) op <= 2'd0;
  endtask
  task automatic take_at(logic [15:0] e);
    int i;
    for (i = 0; i < 60 && take !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    tmo(i < 60);
    chk("vector", vaddr, e);
  endtask
  task automatic quiet(string nm);
    repeat (12) begin
      @(posedge clk);
      #1;
      chk(nm, {15'h0000, take}, 16'h0000);
    end
  endtask
  task automatic rst(logic f, logic [15:0] e);
    int i;
    fuse <= f;
    reset_n <= 1'b0;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    for (i = 0; i < 4 && rvv !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    tmo(i < 4);
    chk("reset vector", vaddr, e);
  endtask
  // main sequence
  initial begin
    rst(1'b1, CIH_BOOT_RESET);
    rst(1'b0, 16'h0000);
    r(CIH_ADDR_SP_HIGH, 8'h00, "sp high");
    w(CIH_ADDR_SP_LOW, 8'ha5);
    w(CIH_ADDR_SP_HIGH, 8'h12);
    r(CIH_ADDR_SP_HIGH, 8'h12, "sp high");
    r(4'hf, 8'h00, "unmapped");
    r(CIH_ADDR_BOOT_HI, CIH_BOOT_RESET[15:8], "boot start");
    pulse(8'h0e);
    r(CIH_ADDR_FLAGS, 8'h0e, "held flags");
    w(CIH_ADDR_FLAGS, 8'h00);
    r(CIH_ADDR_FLAGS, 8'h0e, "write zero");
    w(CIH_ADDR_FLAGS, 8'h04);
    r(CIH_ADDR_FLAGS, 8'h0a, "write one");
    w(CIH_ADDR_ENABLES, 8'h0a);
    quiet("global off");
    w(CIH_ADDR_CONTROL, 8'h02);
    take_at(16'h0004);
    r(CIH_ADDR_CONTROL, 8'h00, "global cleared");
    r(CIH_ADDR_FLAGS, 8'h08, "flag cleared");
    r(CIH_ADDR_SP_LOW, 8'ha3, "sp push");
    go(2'd3);
    take_at(16'h0008);
    w(CIH_ADDR_ENABLES, 8'h0b);
    w(CIH_ADDR_CONTROL, 8'h02);
    pulse(8'h01);
    take_at(16'h0002);
    r(CIH_ADDR_SP_LOW, 8'ha1, "nested sp");
    go(2'd3);
    go(2'd3);
    quiet("nothing pending");
    r(CIH_ADDR_SP_LOW, 8'ha5, "sp pop");
    // enable then disable on consecutive boundaries
    w(CIH_ADDR_CONTROL, 8'h00);
    pulse(8'h01);
    @(posedge clk) op <= 2'd1;
    @(posedge clk) op <= 2'd2;
    @(posedge clk) op <= 2'd0;
    quiet("enable then disable");
    r(CIH_ADDR_FLAGS, 8'h01, "still pending");
    go(2'd1);
    take_at(16'h0002);
    go(2'd3);
    // boot section locked while the table sits low
    pc_v <= CIH_BOOT_RESET;
    block <= 1'b1;
    pulse(8'h08);
    quiet("boot locked");
    @(posedge clk) block <= 1'b0;
    pc_v <= 16'h0000;
    slp <= 1'b1;
    take_at(16'h0008);
    slp <= 1'b0;
    go(2'd3);
    // relocated table, first behind the lock
    lock <= 1'b1;
    w(CIH_ADDR_CONTROL, 8'h03);
    pulse(8'h02);
    quiet("locked out");
    @(posedge clk) lock <= 1'b0;
    take_at(16'h3804);
    go(2'd3);
    // level source: a brief condition is forgotten, a held one served
    is_lvl <= 8'h10;
    @(posedge clk) lvl <= 8'h10;
    @(posedge clk) lvl <= 8'h00;
    w(CIH_ADDR_ENABLES, 8'h1b);
    quiet("vanished level");
    @(posedge clk) lvl <= 8'h10;
    slow <= 1'b1;
    take_at(16'h380a);
    give_verdict();
  end
endmodule // testbench
